// *** rtl/pseq_consts.svh ***
// constant values of the program sequencer
`ifndef PSEQ_CONSTS_SVH
`define PSEQ_CONSTS_SVH
`define PSEQ_ADDR_W 11
`define PSEQ_WORD_W 14
`define PSEQ_LAST_PHASE 2'h3
`define PSEQ_ADDR_RESET 11'h000
`define PSEQ_VEC_EXT0 11'h004
`define PSEQ_VEC_EXT1 11'h008
`define PSEQ_VEC_TIMER 11'h00C
`define PSEQ_VEC_TBASE 11'h010
`define PSEQ_VEC_RTC 11'h014
`define PSEQ_LAST_PAGE 3'h7
`define PSEQ_PAGE_BITS 10:8
`define PSEQ_LOW_BITS 7:0
`define PSEQ_HIGH_BITS 13:8
`define PSEQ_STACK_DEPTH 4
`define PSEQ_IRQ_N 5
`define PSEQ_BUS_IDX_BITS 5:2
`define PSEQ_IDX_PC_LOW_BYTE 4'h6
`define PSEQ_IDX_TABLE_POINTER 4'h7
`define PSEQ_IDX_TABLE_HIGH_BYTE 4'h8
`define PSEQ_IDX_IRQ_CONTROL 4'hC
`define PSEQ_IDX_SEQ_STATUS 4'hD
`define PSEQ_IRQ_GLOBAL_BIT 0
`define PSEQ_IRQ_EN_BITS 5:1
`define PSEQ_IRQ_FLAG_BITS 12:8
`define PSEQ_STAT_IDX_BITS 2:0
`define PSEQ_STAT_HALT_BIT 4
`define PSEQ_SST_PERIODS 1024
`define PSEQ_SYS_PER_CLK 1
`define PSEQ_SST_CYCLES (`PSEQ_SST_PERIODS * `PSEQ_SYS_PER_CLK)
`endif

// *** rtl/pseq_pkg.sv ***
// types shared by the program sequencer
`include "pseq_consts.svh"
package pseq_pkg;
	typedef logic [`PSEQ_ADDR_W-1:0] pseq_addr_t;
	typedef logic [`PSEQ_WORD_W-1:0] pseq_word_t;
	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_START} pseq_state_e;
endpackage : pseq_pkg

// *** rtl/pseq_top.sv ***
// program sequencer: pipeline, program counter, stack and table reads
`timescale 1ns/100ps
`include "pseq_consts.svh"
module pseq_top #(
	parameter int STARTUP_CYCLES = `PSEQ_SST_CYCLES,
	parameter int STACK_DEPTH = `PSEQ_STACK_DEPTH
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output pseq_pkg::pseq_addr_t rom_addr,
	input wire pseq_pkg::pseq_word_t rom_data,
	output pseq_pkg::pseq_word_t instr_word,
	output logic instr_valid,
	output logic [1:0] phase,
	input wire logic exec_jump,
	input wire logic exec_call,
	input wire logic exec_return_call,
	input wire logic exec_return_isr,
	input wire logic exec_skip,
	input wire logic exec_tab_cur,
	input wire logic exec_tab_last,
	input wire logic exec_halt,
	input wire pseq_pkg::pseq_addr_t exec_target,
	output logic [7:0] tab_low_data,
	output logic tab_low_we,
	input wire logic ext_irq0_n,
	input wire logic ext_irq1_n,
	input wire logic timer_ovf,
	input wire logic time_base_tick,
	input wire logic rtc_tick,
	input wire logic wake_req,
	output logic stack_full,
	output logic halted
);
	import pseq_pkg::*;

	localparam int CW = $clog2(STARTUP_CYCLES) + 1;
	localparam logic [2:0] FULL_IDX = 3'(STACK_DEPTH);

	// ----------------------------------------
	// state
	// ----------------------------------------
	pseq_state_e st_reg, st_next;
	logic [1:0] phase_reg;
	logic [CW-1:0] start_cnt_reg;
	pseq_addr_t prog_cnt_reg, prog_cnt_next;
	pseq_addr_t rom_addr_reg, rom_addr_next;
	pseq_word_t instr_reg, instr_next;
	logic valid_reg, valid_next;
	logic tab_cycle_reg;
	logic [7:0] table_pointer_reg;
	logic [7:0] table_high_byte_reg;
	logic [7:0] tab_low_reg;
	logic tab_we_reg;
	pseq_addr_t stack_mem [STACK_DEPTH];
	logic [2:0] stack_index_reg, stack_index_next;
	logic full_reg, halted_reg;
	logic [`PSEQ_IRQ_N-1:0] flags_reg, flags_next, enables_reg;
	logic global_reg, global_next;
	logic irq0_prev_reg, irq1_prev_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic pcl_pend_reg;
	logic [7:0] pc_low_byte_wr_reg;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire run = st_reg == ST_RUN;
	wire ph3 = phase_reg == `PSEQ_LAST_PHASE;
	wire step = ph3 & run;
	wire ev = step & valid_reg;
	wire do_call = ev & exec_call;
	wire do_jump = ev & (exec_jump | exec_call);
	wire do_ret = ev & (exec_return_call | exec_return_isr);
	wire do_skip = ev & exec_skip;
	wire do_tab = ev & (exec_tab_cur | exec_tab_last);
	wire do_halt = ev & exec_halt;
	wire ctrl_any = exec_jump | exec_call | exec_return_call |
		exec_return_isr | exec_skip | exec_tab_cur | exec_tab_last |
		exec_halt;
	wire busy = tab_cycle_reg | (valid_reg & ctrl_any);
	wire is_full = stack_index_reg == FULL_IDX;
	wire [`PSEQ_IRQ_N-1:0] irq_req = flags_reg & enables_reg;
	wire [`PSEQ_IRQ_N-1:0] irq_sel = irq_req & (~irq_req + 5'h01);
	wire irq_go = step & ~busy & ~pcl_pend_reg & global_reg &
		(|irq_req) & ~is_full;
	wire pcl_go = step & ~busy & pcl_pend_reg;
	wire flush = irq_go | pcl_go | do_jump | do_ret | do_skip | do_tab |
		do_halt;
	wire push = do_call | irq_go;
	wire pop = do_ret;

	// first source in bit order wins
	wire pseq_addr_t irq_vec = irq_sel[0] ? `PSEQ_VEC_EXT0 :
		irq_sel[1] ? `PSEQ_VEC_EXT1 :
		irq_sel[2] ? `PSEQ_VEC_TIMER :
		irq_sel[3] ? `PSEQ_VEC_TBASE : `PSEQ_VEC_RTC;

	wire pseq_addr_t short_jump = {prog_cnt_reg[`PSEQ_PAGE_BITS],
		pc_low_byte_wr_reg};
	wire pseq_addr_t tab_addr = exec_tab_last ?
		{`PSEQ_LAST_PAGE, table_pointer_reg} :
		{prog_cnt_reg[`PSEQ_PAGE_BITS], table_pointer_reg};

	// ----------------------------------------
	// counter and fetch
	// ----------------------------------------
	// skip and dummies simply advance: the dropped word is not replayed
	assign prog_cnt_next = !step ? prog_cnt_reg :
		irq_go ? irq_vec :
		pcl_go ? short_jump :
		do_jump ? exec_target :
		do_ret ? stack_mem[0] :
		(do_tab | do_halt) ? prog_cnt_reg :
		prog_cnt_reg + 11'h001;
	assign rom_addr_next = !step ? rom_addr_reg :
		do_tab ? tab_addr : prog_cnt_next;
	assign instr_next = (step & ~tab_cycle_reg) ? rom_data :
		instr_reg;
	// table cycle keeps the word fetched beside the table instruction
	assign valid_next = !step ? valid_reg :
		tab_cycle_reg ? 1'b1 : ~flush;
	assign stack_index_next = push ?
		(is_full ? stack_index_reg : stack_index_reg + 3'h1) :
		pop ? (stack_index_reg == 3'h0 ? stack_index_reg :
		stack_index_reg - 3'h1) : stack_index_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= 2'h0;
			prog_cnt_reg <= `PSEQ_ADDR_RESET;
			rom_addr_reg <= `PSEQ_ADDR_RESET;
			instr_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			phase_reg <= run ? phase_reg + 2'h1 : 2'h0;
			prog_cnt_reg <= prog_cnt_next;
			rom_addr_reg <= rom_addr_next;
			instr_reg <= instr_next;
			valid_reg <= valid_next;
		end
	end

	// ----------------------------------------
	// table read
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tab_cycle_reg <= 1'b0;
			tab_we_reg <= 1'b0;
			tab_low_reg <= 8'h00;
			table_high_byte_reg <= 8'h00;
		end else begin
			tab_cycle_reg <= step ? do_tab : tab_cycle_reg;
			tab_we_reg <= step & tab_cycle_reg;
			if (step & tab_cycle_reg) begin
				tab_low_reg <= rom_data[`PSEQ_LOW_BITS];
				table_high_byte_reg <= {2'h0, rom_data[`PSEQ_HIGH_BITS]};
			end
		end
	end

	// ----------------------------------------
	// return stack
	// ----------------------------------------
	// shifting stack: a push when full pushes the oldest out the bottom
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_mem[i] <= `PSEQ_ADDR_RESET;
			end
			stack_index_reg <= 3'h0;
			full_reg <= 1'b0;
		end else begin
			if (push) begin
				stack_mem[0] <= prog_cnt_reg;
				for (int i = 1; i < STACK_DEPTH; i++) begin
					stack_mem[i] <= stack_mem[i-1];
				end
			end else if (pop) begin
				for (int i = 0; i < STACK_DEPTH-1; i++) begin
					stack_mem[i] <= stack_mem[i+1];
				end
			end
			stack_index_reg <= stack_index_next;
			full_reg <= stack_index_next == FULL_IDX;
		end
	end

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	wire fall0 = irq0_prev_reg & ~ext_irq0_n;
	wire fall1 = irq1_prev_reg & ~ext_irq1_n;
	wire [`PSEQ_IRQ_N-1:0] set_vec = {rtc_tick, time_base_tick,
		timer_ovf, fall1, fall0};
	wire [3:0] bus_idx = avs_address[`PSEQ_BUS_IDX_BITS];
	wire bus_req = avs_read | avs_write;
	wire wr_fire = avs_write & ~wait_reg;
	wire irq_wr = wr_fire & (bus_idx == `PSEQ_IDX_IRQ_CONTROL);
	wire [`PSEQ_IRQ_N-1:0] ack_clr = irq_go ? irq_sel : '0;
	wire [`PSEQ_IRQ_N-1:0] sw_clr = irq_wr ?
		~avs_writedata[`PSEQ_IRQ_FLAG_BITS] : '0;
	// new events win over any clear in the same cycle
	assign flags_next = (flags_reg & ~ack_clr & ~sw_clr) | set_vec;
	assign global_next = irq_go ? 1'b0 :
		(do_ret & exec_return_isr) ? 1'b1 :
		irq_wr ? avs_writedata[`PSEQ_IRQ_GLOBAL_BIT] : global_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= '0;
			enables_reg <= '0;
			global_reg <= 1'b0;
			irq0_prev_reg <= 1'b1;
			irq1_prev_reg <= 1'b1;
		end else begin
			flags_reg <= flags_next;
			if (irq_wr) begin
				enables_reg <= avs_writedata[`PSEQ_IRQ_EN_BITS];
			end
			global_reg <= global_next;
			irq0_prev_reg <= ext_irq0_n;
			irq1_prev_reg <= ext_irq1_n;
		end
	end

	// ----------------------------------------
	// halt and start-up
	// ----------------------------------------
	wire start_done = start_cnt_reg == CW'(STARTUP_CYCLES - 1);

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_RUN: begin
				if (do_halt) begin
					st_next = ST_HALT;
				end
			end
			ST_HALT: begin
				if (wake_req | (|flags_reg)) begin
					st_next = ST_START;
				end
			end
			ST_START: begin
				if (start_done) begin
					st_next = ST_RUN;
				end
			end
			default: st_next = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= ST_RUN;
			start_cnt_reg <= '0;
			halted_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			start_cnt_reg <= (st_reg == ST_START) ?
				start_cnt_reg + CW'(1) : '0;
			halted_reg <= st_next != ST_RUN;
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	wire [31:0] rd_value =
		(bus_idx == `PSEQ_IDX_PC_LOW_BYTE) ?
			{24'h0, prog_cnt_reg[`PSEQ_LOW_BITS]} :
		(bus_idx == `PSEQ_IDX_TABLE_POINTER) ?
			{24'h0, table_pointer_reg} :
		(bus_idx == `PSEQ_IDX_TABLE_HIGH_BYTE) ?
			{24'h0, table_high_byte_reg} :
		(bus_idx == `PSEQ_IDX_IRQ_CONTROL) ?
			{19'h0, flags_reg, 2'h0, enables_reg, global_reg} :
		(bus_idx == `PSEQ_IDX_SEQ_STATUS) ?
			{27'h0, halted_reg, 1'b0, stack_index_reg} : 32'h0;
	wire pcl_wr = wr_fire & (bus_idx == `PSEQ_IDX_PC_LOW_BYTE);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0;
			pcl_pend_reg <= 1'b0;
			pc_low_byte_wr_reg <= 8'h00;
			table_pointer_reg <= 8'h00;
		end else begin
			wait_reg <= ~(bus_req & wait_reg);
			if (bus_req & wait_reg) begin
				rdata_reg <= rd_value;
			end
			pcl_pend_reg <= pcl_wr | (pcl_pend_reg & ~pcl_go);
			if (pcl_wr) begin
				pc_low_byte_wr_reg <= avs_writedata[`PSEQ_LOW_BITS];
			end
			if (wr_fire & (bus_idx == `PSEQ_IDX_TABLE_POINTER)) begin
				table_pointer_reg <= avs_writedata[`PSEQ_LOW_BITS];
			end
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign rom_addr = rom_addr_reg;
	assign instr_word = instr_reg;
	assign instr_valid = valid_reg;
	assign phase = phase_reg;
	assign tab_low_data = tab_low_reg;
	assign tab_low_we = tab_we_reg;
	assign stack_full = full_reg;
	assign halted = halted_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_phase_step: assert property (run |=>
		phase_reg == $past(phase_reg) + 2'h1)
		else $error("phase did not advance");
	a_fetch_inc: assert property (step & ~flush & ~tab_cycle_reg |=>
		prog_cnt_reg == $past(prog_cnt_reg) + 11'h001)
		else $error("counter did not increment");
	a_transfer_dummy: assert property (do_jump |=>
		!valid_reg [*4])
		else $error("transfer without dummy cycle");
	a_skip_drop: assert property (do_skip |=> !valid_reg &&
		rom_addr_reg == $past(prog_cnt_reg) + 11'h001)
		else $error("skip did not drop word");
	a_short_jump: assert property (pcl_go |=>
		prog_cnt_reg == {$past(prog_cnt_reg[`PSEQ_PAGE_BITS]),
		$past(pc_low_byte_wr_reg)})
		else $error("short jump left page");
	a_irq_vector: assert property (irq_go |=>
		prog_cnt_reg == $past(irq_vec) && !global_reg &&
		stack_mem[0] == $past(prog_cnt_reg))
		else $error("bad interrupt entry");
	a_jump_target: assert property (do_jump & ~exec_call |=>
		prog_cnt_reg == $past(exec_target))
		else $error("jump missed target");
	a_table_two: assert property (do_tab |=>
		tab_cycle_reg [*4] ##1 (tab_low_we && !tab_cycle_reg))
		else $error("table read length wrong");
	a_full_hold: assert property (is_full |-> !irq_go)
		else $error("interrupt taken on full stack");
	a_call_overflow: assert property (do_call & is_full |=>
		stack_index_reg == FULL_IDX &&
		stack_mem[0] == $past(prog_cnt_reg))
		else $error("overflow lost newest entry");
	a_startup_wait: assert property (st_reg == ST_START & ~start_done |=>
		st_reg == ST_START && !valid_reg)
		else $error("start-up cut short");

	c_irq_taken: cover property (irq_go ##1 do_ret);
	c_overflow: cover property (do_call & is_full);
	c_table_last: cover property (do_tab & exec_tab_last);
	c_wake: cover property (st_reg == ST_START ##1 run);

endmodule : pseq_top

// *** test/pseq_rom_model.sv ***
// program memory model standing behind the fetch port
`timescale 1ns/100ps
module pseq_rom_model #(
	parameter int LAT = 2
) (
	input wire logic core_clk,
	input wire pseq_pkg::pseq_addr_t rom_addr,
	output pseq_pkg::pseq_word_t rom_data
);
	import pseq_pkg::*;
	pseq_addr_t last_addr;
	int wait_cnt = 0;
	initial rom_data = '0;
	// ------------------------------
	// read port
	// ------------------------------
	// data toggles while settling, so an early sample sees garbage
	always @(posedge core_clk) begin
		last_addr <= rom_addr;
		if (rom_addr !== last_addr || wait_cnt > 1) begin
			wait_cnt <= (rom_addr !== last_addr) ? LAT : wait_cnt - 1;
			rom_data <= ~rom_data;
		end else begin
			rom_data <= {rom_addr[2:0] ^ 3'h5, rom_addr};
		end
	end
endmodule : pseq_rom_model

// *** test/program_sequencer_tb.sv ***
// self-checking bench of the program sequencer
`timescale 1ns/100ps
module program_sequencer_tb;
	import pseq_pkg::*;
	logic core_clk = 0;
	logic rstn = 0;
	logic [5:0] avs_address = '0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pseq_addr_t rom_addr;
	pseq_word_t rom_data;
	pseq_word_t instr_word;
	logic instr_valid;
	logic [1:0] phase;
	logic [7:0] ex = '0;
	pseq_addr_t exec_target = '0;
	logic [7:0] tab_low_data;
	logic tab_low_we;
	logic [4:0] src = '0;
	logic wake_req = 0;
	logic stack_full;
	logic halted;
	int error_cnt = 0;
	int total_checks = 0;
	int we_cnt = 0;
	int n;
	logic [31:0] rd;
	// rows: {source index, expected vector}
	localparam logic [13:0] ROWS [5] = '{14'h0004, 14'h0808, 14'h100C,
		14'h1810, 14'h2014};
	// ------------------------------
	// clock, design, partner
	// ------------------------------
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (tab_low_we === 1'b1) we_cnt <= we_cnt + 1;
	pseq_top #(.STARTUP_CYCLES(8)) pseq_top_inst (
		.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .rom_addr,
		.rom_data, .instr_word, .instr_valid, .phase,
		.exec_jump(ex[0]), .exec_call(ex[1]), .exec_return_call(ex[2]),
		.exec_return_isr(ex[3]), .exec_skip(ex[4]), .exec_tab_cur(ex[5]),
		.exec_tab_last(ex[6]), .exec_halt(ex[7]), .exec_target,
		.tab_low_data, .tab_low_we, .ext_irq0_n(~src[0]),
		.ext_irq1_n(~src[1]), .timer_ovf(src[2]), .time_base_tick(src[3]),
		.rtc_tick(src[4]), .wake_req, .stack_full, .halted
	);
	pseq_rom_model pseq_rom_model_inst (.core_clk, .rom_addr, .rom_data);
	// ------------------------------
	// tasks
	// ------------------------------
	function automatic pseq_word_t w(pseq_addr_t a);
		return {a[2:0] ^ 3'h5, a};
	endfunction : w
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic tmo;
		error_cnt++;
		$display("mismatch wait exp done seen timeout");
		end_of_test();
	endtask : tmo
	task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
		int i;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 32; i++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		if (i == 32) tmo();
	endtask : bus
	// one instruction of kind k, held through its phase 3
	task automatic op(int k, pseq_addr_t t);
		int i;
		for (i = 0; i < 64; i++) begin
			@(posedge core_clk);
			#1;
			if (phase == 2'h2 && instr_valid === 1'b1) break;
		end
		if (i == 64) tmo();
		@(posedge core_clk);
		ex <= 8'h01 << k;
		exec_target <= t;
		@(posedge core_clk);
		ex <= '0;
		#1;
	endtask : op
	task automatic wv;
		for (n = 0; n < 64; n++) begin
			if (instr_valid === 1'b1) break;
			@(posedge core_clk);
			#1;
		end
		if (n == 64) tmo();
	endtask : wv
	task automatic wa(pseq_addr_t a);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge core_clk);
			#1;
			if (rom_addr === a) break;
		end
		chk("rom_addr", rom_addr, a);
		if (i == 200) tmo();
	endtask : wa
	// ------------------------------
	// sequence
	// ------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		chk("rom_addr", rom_addr, 0);
		chk("stack_full", stack_full, 0);
		rstn <= 1;
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1;
			chk("phase", phase, (i + 1) % 4);
		end
		chk("instr", instr_word, w(11'h001));
		bus(0, 6'h34, 0);
		chk("seq_status", rd, 0);
		bus(1, 6'h1C, 32'h45);
		bus(0, 6'h1C, 0);
		chk("table_pointer", rd, 32'h45);
		bus(0, 6'h3C, 0);
		chk("unmapped", rd, 0);
		op(0, 11'h155);
		chk("rom_addr", rom_addr, 11'h155);
		wv();
		chk("dummy", n, 4);
		chk("instr", instr_word, w(11'h155));
		op(4, 0);
		wv();
		chk("skip", instr_word, w(11'h157));
		bus(1, 6'h18, 32'h20);
		wa(11'h120);
		wv();
		chk("dummy", n, 4);
		chk("instr", instr_word, w(11'h120));
		op(5, 0);
		chk("rom_addr", rom_addr, 11'h145);
		wv();
		chk("tab_cycles", n, 4);
		bus(1, 6'h20, 32'hFF);
		bus(0, 6'h20, 0);
		chk("table_high", rd, w(11'h145) >> 8);
		chk("tab_low", tab_low_data, 8'(w(11'h145)));
		chk("tab_we", we_cnt, 1);
		op(6, 0);
		chk("rom_addr", rom_addr, 11'h745);
		wv();
		chk("tab_cycles", n, 4);
		bus(0, 6'h20, 0);
		chk("table_high", rd, w(11'h745) >> 8);
		chk("tab_low", tab_low_data, 8'(w(11'h745)));
		chk("tab_we", we_cnt, 2);
		foreach (ROWS[r]) begin
			bus(1, 6'h30, 1 | (2 << ROWS[r][13:11]));
			@(posedge core_clk);
			src <= 5'h01 << ROWS[r][13:11];
			@(posedge core_clk);
			src <= '0;
			wa(ROWS[r][10:0]);
			bus(0, 6'h30, 0);
			chk("irq_control", rd, 2 << ROWS[r][13:11]);
			op(3, 0);
		end
		for (int i = 0; i < 5; i++) op(1, 11'h300 + 11'(i * 16));
		chk("stack_full", stack_full, 1);
		bus(0, 6'h34, 0);
		chk("seq_status", rd, 4);
		bus(1, 6'h30, 32'h9);
		@(posedge core_clk);
		src <= 5'h04;
		@(posedge core_clk);
		src <= '0;
		repeat (16) @(posedge core_clk);
		bus(0, 6'h30, 0);
		chk("irq_held", rd, 32'h409);
		op(2, 0);
		wa(11'h00C);
		op(3, 0);
		for (int i = 0; i < 3; i++) begin
			op(2, 0);
			wa(11'h331 - 11'(i * 16));
		end
		op(7, 0);
		chk("halted", halted, 1);
		@(posedge core_clk);
		wake_req <= 1;
		for (n = 0; n < 64 && halted !== 1'b0; n++) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		wake_req <= 0;
		chk("startup", n >= 8 && n < 16, 1);
		end_of_test();
	end
endmodule : program_sequencer_tb
